// ===== hdl/rot_unit.sv
/*
 * rot_unit: execute logic for the rotate-left-no-carry, rotate-right-
 * through-carry and rotate-left-through-carry instructions.
 * assumes: the decoder presents one instruction word with a one-cycle
 * valid; data memory answers a read in the cycle after the read strobe;
 * all inputs are synchronous to i_clk.
 */
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// RL1: rotate left, bit7 to bit0, N Z only
// RL2: rotate right, bit0 into C, C into bit7
// RL3: decode right-through-carry from 0011 00da
// RL4: dest 0 writes W, 1 writes file
// RL5: bank 0 access bank, 1 bank_select_reg
// RL6: extended, bank 0, f<=5Fh uses indexed offset
// RL7: rotate left, bit7 into C, C into bit0
// RL8: one word, decode read process write phases
module rot_unit (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // instruction from the decoder
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic [11:0] i_index_base,
    // data memory
    output rot_pkg::rot_mem_s o_mem,
    input wire logic [7:0] i_mem_rdata,
    // software register port
    input rot_pkg::rot_reg_s i_reg,
    output logic [7:0] o_reg_rdata,
    // status towards the core
    output logic o_busy,
    output logic o_done,
    output logic o_illegal,
    output logic [7:0] o_work
);
    import rot_pkg::*;

    // the whole state of the unit
    typedef struct packed {
        rot_phase_e ph;           // current phase
        rot_kind_e kind;          // latched operation
        logic dest;               // 1 = back to file
        logic ext;                // extended instruction set enabled
        logic [3:0] bank;         // bank_select_reg
        logic [7:0] work;         // working register
        logic c;                  // carry flag
        logic z;                  // zero flag
        logic n;                  // negative flag
        logic [7:0] rdata;        // read data for the software port
        rot_mem_s mem;            // memory request
        logic done;               // instruction finished pulse
        logic illegal;            // not a rotate pulse
    } rot_state_s;

    rot_state_s st_r;
    rot_state_s st_nxt;

    // maps the upper opcode bits onto an operation
    function automatic rot_kind_e rot_decode(input logic [5:0] opc);
        rot_kind_e k;
        k = ROT_NONE;
        if (opc == OPC_RLNC) begin
            k = ROT_LNC;
        end else if (opc == OPC_RRC) begin
            k = ROT_RC;   // see RL3
        end else if (opc == OPC_RLC) begin
            k = ROT_LC;
        end
        return k;
    endfunction

    // forms the 12-bit data address from the file field and bank bit
    function automatic logic [11:0] rot_addr(input logic [7:0] f, input logic a,
                                             input logic ext, input logic [3:0] bank,
                                             input logic [11:0] base);
        logic [11:0] ad;
        ad = {bank, f};   // see RL5
        // access bank: low offsets sit in bank 0, or at the indexed base when extended, the rest in the top bank
        if (!a) begin
            if (ext && (f <= IDX_LIMIT)) begin
                ad = base + {4'h0, f};   // see RL6
            end else if (f <= IDX_LIMIT) begin
                ad = {4'h0, f};   // see RL5
            end else begin
                ad = {ACC_HI_BANK, f};
            end
        end
        return ad;
    endfunction

    // rotate result and its carry-out, only meaningful in the third phase
    logic [7:0] res;
    logic res_c;

    // rotate datapath on the operand read in the second phase
    always_comb begin
        res = i_mem_rdata;
        res_c = st_r.c;
        case (st_r.kind)
            ROT_LNC: begin
                res = {i_mem_rdata[6:0], i_mem_rdata[7]};   // see RL1
            end
            ROT_RC: begin
                res = {st_r.c, i_mem_rdata[7:1]};   // see RL2
                res_c = i_mem_rdata[0];
            end
            ROT_LC: begin
                res = {i_mem_rdata[6:0], st_r.c};   // see RL7
                res_c = i_mem_rdata[7];
            end
            default: begin
                res = i_mem_rdata;
            end
        endcase
    end

    // next state: sequencer, register port and flag updates
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.illegal = 1'b0;
        st_nxt.mem.rd = 1'b0;
        st_nxt.mem.wr = 1'b0;
        // software writes first so that same-cycle hardware updates win
        if (i_reg.wr) begin
            if (i_reg.addr == REG_CTRL) begin
                st_nxt.ext = i_reg.wdata[0];
            end else if (i_reg.addr == REG_BANK) begin
                st_nxt.bank = i_reg.wdata[3:0];
            end else if (i_reg.addr == REG_WORK) begin
                st_nxt.work = i_reg.wdata;
            end else if (i_reg.addr == REG_STAT) begin
                // the busy bit is read only, a write to it is dropped
                st_nxt.c = i_reg.wdata[ST_C];
                st_nxt.z = i_reg.wdata[ST_Z];
                st_nxt.n = i_reg.wdata[ST_N];
            end
        end
        // read data stand only in the cycle after the strobe
        // unmapped offsets leave the read data at 00
        st_nxt.rdata = 8'h00;
        if (i_reg.rd) begin
            if (i_reg.addr == REG_CTRL) begin
                st_nxt.rdata = {7'h00, st_r.ext};
            end else if (i_reg.addr == REG_BANK) begin
                st_nxt.rdata = {4'h0, st_r.bank};
            end else if (i_reg.addr == REG_WORK) begin
                st_nxt.rdata = st_r.work;
            end else if (i_reg.addr == REG_STAT) begin
                st_nxt.rdata = {st_r.ph != PH_IDLE, 2'b00, st_r.n, 1'b0, st_r.z, 1'b0,
                                st_r.c};
            end
        end
        case (st_r.ph)
            PH_Q2: begin
                // memory returns the operand during the third phase
                st_nxt.ph = PH_Q3;
            end
            PH_Q3: begin
                // process and queue the destination write, see RL8
                st_nxt.ph = PH_Q4;
                // flags follow the result whatever the destination
                st_nxt.n = res[7];
                st_nxt.z = (res == 8'h00);
                // left-no-carry keeps carry so a chained operation can still use it
                if (st_r.kind != ROT_LNC) begin
                    st_nxt.c = res_c;   // see RL2
                end
                if (st_r.dest) begin
                    st_nxt.mem.wr = 1'b1;   // see RL4
                    st_nxt.mem.wdata = res;
                end else begin
                    st_nxt.work = res;   // see RL4
                end
            end
            default: begin
                // idle or fourth phase: a new word may be decoded here
                if (st_r.ph == PH_Q4) begin
                    st_nxt.done = 1'b1;
                end
                st_nxt.ph = PH_IDLE;
                if (i_instr_valid) begin
                    // a refused word clears the latched kind, so the datapath idles
                    st_nxt.kind = rot_decode(i_instr[15:10]);
                    if (rot_decode(i_instr[15:10]) == ROT_NONE) begin
                        st_nxt.illegal = 1'b1;
                    end else begin
                        // decode in the first phase, read in the second, see RL8
                        st_nxt.ph = PH_Q2;
                        st_nxt.dest = i_instr[DEST_BIT];
                        st_nxt.mem.rd = 1'b1;
                        st_nxt.mem.addr = rot_addr(i_instr[7:0], i_instr[BANK_BIT],
                                                   st_r.ext, st_r.bank, i_index_base);
                    end
                end
            end
        endcase
    end

    // single state register; async reset loads constants only
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= '{ph: PH_IDLE, kind: ROT_NONE, dest: 1'b1, ext: 1'b0, bank: BANK_RST,
                      work: WORK_RST, c: 1'b0, z: 1'b0, n: 1'b0, rdata: 8'h00,
                      mem: '0, done: 1'b0, illegal: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state
    assign o_mem = st_r.mem;
    assign o_reg_rdata = st_r.rdata;
    assign o_busy = (st_r.ph != PH_IDLE);
    assign o_done = st_r.done;
    assign o_illegal = st_r.illegal;
    assign o_work = st_r.work;
endmodule

// ===== hdl/rot_pkg.sv
/*
 * rot_pkg: constants, opcode kinds, sequencer states and carrier structs
 * for the rotate execute unit.
 * assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses.
 */
package rot_pkg;
    // upper six opcode bits of the three rotate instructions
    localparam logic [5:0] OPC_RLNC = 6'h11;   // 0100 01da
    localparam logic [5:0] OPC_RRC = 6'h0c;    // 0011 00da
    localparam logic [5:0] OPC_RLC = 6'h0d;    // 0011 01da
    // instruction field positions
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    // indexed literal offset applies to file addresses up to this value
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    // access bank: low part in bank 0 (indexed base when extended), upper part in the top bank
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    // register offsets on the software port
    localparam logic [3:0] REG_CTRL = 4'h0;    // bit0 extended set enable
    localparam logic [3:0] REG_BANK = 4'h1;    // bank_select_reg, low 4 bits
    localparam logic [3:0] REG_WORK = 4'h2;    // working register
    localparam logic [3:0] REG_STAT = 4'h3;    // flags and phase
    // flag positions inside the status register
    localparam int ST_C = 0;
    localparam int ST_Z = 2;
    localparam int ST_N = 4;
    localparam int ST_BUSY = 7;
    // reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;

    typedef enum {ROT_NONE, ROT_LNC, ROT_RC, ROT_LC} rot_kind_e;
    typedef enum {PH_IDLE, PH_Q2, PH_Q3, PH_Q4} rot_phase_e;

    // data memory side request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } rot_mem_s;

    // software register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rot_reg_s;
endpackage

// ===== test/rot_unit_checker.sv
/* port assertions for rot_unit; assumes one clock, async active-low reset */
`timescale 1ns/1ps
module rot_unit_checker
    import rot_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input rot_mem_s o_mem,
    input wire logic [7:0] i_mem_rdata,
    input rot_reg_s i_reg,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_illegal
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0] rd_q;  // read data of the previous cycle
    logic take;        // word accepted at this edge
    logic rot;         // word is one of the rotates
    assign take = i_instr_valid && !o_busy;
    assign rot = i_instr[15:10] inside {OPC_RLNC, OPC_RRC, OPC_RLC};
    always_ff @(posedge i_clk) rd_q <= i_mem_rdata;
    AST_READ: assert property (take && rot |=> o_mem.rd)
        else $error("rotate word gave no read");
    AST_ILLEGAL: assert property (take && !rot |=> o_illegal && !o_mem.rd)
        else $error("foreign word not refused");
    AST_DONE: assert property (o_mem.rd |-> ##3 o_done)
        else $error("done not three cycles after read");
    AST_BUSY: assert property (o_mem.rd |-> o_busy [*3])
        else $error("busy dropped early");
    AST_BANKED: assert property (take && rot && i_instr[8] |=>
        o_mem.addr[7:0] == $past(i_instr[7:0])) else $error("banked offset wrong");
    AST_ACC_HI: assert property (take && rot && !i_instr[8] && i_instr[7:0] > IDX_LIMIT
        |=> o_mem.addr == {ACC_HI_BANK, $past(i_instr[7:0])}) else $error("access bank wrong");
    AST_FILE_WR: assert property (take && rot && i_instr[9] |=> ##2 o_mem.wr)
        else $error("file result not written");
    AST_W_ONLY: assert property (take && rot && !i_instr[9] |=> ##2 !o_mem.wr)
        else $error("file written for W destination");
    AST_RLNC: assert property (take && i_instr[15:9] == {OPC_RLNC, 1'b1} |=> ##2
        o_mem.wdata == {rd_q[6:0], rd_q[7]}) else $error("left rotate data wrong");
    COV_DONE: cover property (o_done);
    COV_ILLEGAL: cover property (o_illegal);
    COV_WRITE: cover property (o_mem.wr);
endmodule

bind rot_unit rot_unit_checker i_rot_unit_checker (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_mem(o_mem), .i_reg(i_reg),
    .i_mem_rdata(i_mem_rdata), .o_reg_rdata(o_reg_rdata), .o_busy(o_busy),
    .o_done(o_done), .o_illegal(o_illegal));

// ===== test/rot_mem_model.sv
/* data memory model; assumes one-cycle read and write strobes from rot_unit */
`timescale 1ns/1ps
module rot_mem_model
    import rot_pkg::*;
(
    input wire logic i_clk,
    input rot_mem_s i_mem,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [4096];  // data file, preloaded by the bench
    initial o_rdata = 8'h00;
    // data stands one cycle only, then flips so stale data never looks valid
    always @(posedge i_clk) begin
        if (i_mem.wr) mem[i_mem.addr] <= i_mem.wdata;
        o_rdata <= i_mem.rd ? mem[i_mem.addr] : ~o_rdata;
    end
endmodule

// ===== test/rot_unit_tb.sv
/* self-checking bench for rot_unit; assumes rot_mem_model on the data side */
`timescale 1ns/1ps
module rot_unit_tb;
    import rot_pkg::*;
    logic i_clk = 0, i_rst_b = 0, i_instr_valid = 0, o_busy, o_done, o_illegal;
    logic [15:0] i_instr = 16'h0000;
    logic [11:0] i_index_base = 12'h200;  // indexed base, held
    logic [7:0] i_mem_rdata, o_reg_rdata, o_work, v;
    rot_mem_s o_mem;
    rot_reg_s i_reg = '0;
    int failures = 0, checks = 0;
    always #2 i_clk = ~i_clk;
    rot_unit i_rot_unit (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_index_base(i_index_base), .o_mem(o_mem), .o_work(o_work),
        .i_mem_rdata(i_mem_rdata), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
        .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal));
    rot_mem_model i_rot_mem_model (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobe; read data is caught in the cycle after it
    task automatic reg_op(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg <= '{wr, !wr, a, d};
        @(posedge i_clk);
        i_reg <= '0;
        #1 v = o_reg_rdata;
    endtask
    // issue one word, then judge result, destination and flags
    task automatic run(input logic [15:0] ins, input logic [11:0] a, input logic [7:0] pre,
                       input logic [7:0] res, input logic [7:0] st);
        i_rot_mem_model.mem[a] = pre;
        @(posedge i_clk);
        i_instr_valid <= 1;
        i_instr <= ins;
        @(posedge i_clk);
        i_instr_valid <= 0;
        repeat (3) @(posedge i_clk);
        #1 chk(o_done, 1);
        chk(ins[9] ? i_rot_mem_model.mem[a] : o_work, res);
        if (!ins[9]) chk(i_rot_mem_model.mem[a], pre);
        reg_op(0, REG_STAT, 8'h00);
        chk(v & 8'h15, st);
    endtask
    task automatic t_regs();
        reg_op(0, REG_WORK, 8'h00);
        chk(v, WORK_RST);
        reg_op(0, 4'h9, 8'h00);
        chk(v, 8'h00);
        reg_op(1, REG_WORK, 8'h5a);
        reg_op(0, REG_WORK, 8'h00);
        chk(v, 8'h5a);
        $display("registers done");
    endtask
    task automatic t_left();
        run(16'h3420, 12'h020, 8'h80, 8'h00, 8'h05);
        run(16'h46ab, 12'hfab, 8'hab, 8'h57, 8'h01);
        $display("left rotates done");
    endtask
    task automatic t_right();
        reg_op(1, REG_BANK, 8'h03);
        run(16'h3110, 12'h310, 8'h01, 8'h80, 8'h11);
        reg_op(1, REG_CTRL, 8'h01);
        run(16'h325f, 12'h25f, 8'he6, 8'hf3, 8'h10);
        $display("right rotates done");
    endtask
    task automatic t_edge();
        run(16'h3460, 12'hf60, 8'he6, 8'hcc, 8'h11);
        @(posedge i_clk);
        i_instr_valid <= 1;
        i_instr <= 16'h6800;
        @(posedge i_clk);
        i_instr_valid <= 0;
        #1 chk(o_illegal, 1);
        chk(o_work, 8'hcc);
        $display("boundary and foreign word done");
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1;
        t_regs();
        t_left();
        t_right();
        t_edge();
        results();
    end
    // watchdog: far beyond the well under one hundred cycles the tests need
    initial begin
        #20000;
        failures++;
        results();
    end
endmodule
